// ==== src/multiplexed_io_pin_control.v ====
// thirty-two multiplexed general pins with power-on defaults
// Behaviour
// RULE1: thirty-two pins, each with enable, direction and pull choice.
// RULE2: pins 0,2,3,11-31 pull-up inputs; 1 and 10 pull-down inputs.
// RULE3: pins 7,8,9 default to address function so boot fetch works.
// RULE4: pins 4,5,6 default to their normal strobe and ready functions.
// RULE5: pins 4,5,7,8,9 as general pins are inputs with pull-up only.
// RULE6: pin 6 as general pin is an input with pull-down only.
// RULE7: pins 26 and 29 return to normal function on low strap.
// RULE8: pin numbers 0-31 map to fixed package functions.
// RULE9: reset drops activity, clears logic, restarts at reset address.
// RULE10: active-low reset pin is synchronised internally.
// RULE11: outside source holds reset low at least 1 ms.
// RULE12: bus clock stable over four periods while reset held.
// RULE13: fetch starts about 6.5 bus clock periods after reset release.
// RULE14: strap sampled one clock after reset release, decides reversion.
// RULE15: disabled pin routes to normal function; enabled follows settings.
`timescale 1ns/1ps
`include "pin_mux_consts.vh"
module multiplexed_io_pin_control #(
    parameter PINS = `PIN_COUNT
) (
    clk,
    rst,
    chip_init_pin_n,
    address_drive_strap,
    cfg_write,
    cfg_func_en,
    cfg_dir_out,
    cfg_pull_up,
    cfg_data_out,
    pin_in,
    normal_out,
    normal_oe_n,
    pin_out,
    pin_oe_n,
    pin_pull_up,
    pin_pull_dn,
    normal_in,
    general_in,
    func_en,
    dir_out,
    pull_up_sel,
    strap_low,
    core_reset,
    fetch_start
);
    input  wire            clk;
    input  wire            rst;
    input  wire            chip_init_pin_n;
    input  wire            address_drive_strap;
    input  wire            cfg_write;
    input  wire [PINS-1:0] cfg_func_en;
    input  wire [PINS-1:0] cfg_dir_out;
    input  wire [PINS-1:0] cfg_pull_up;
    input  wire [PINS-1:0] cfg_data_out;
    input  wire [PINS-1:0] pin_in;
    input  wire [PINS-1:0] normal_out;
    input  wire [PINS-1:0] normal_oe_n;
    output reg  [PINS-1:0] pin_out;
    output reg  [PINS-1:0] pin_oe_n;
    output reg  [PINS-1:0] pin_pull_up;
    output reg  [PINS-1:0] pin_pull_dn;
    output reg  [PINS-1:0] normal_in;
    output reg  [PINS-1:0] general_in;
    output reg  [PINS-1:0] func_en;
    output reg  [PINS-1:0] dir_out;
    output reg  [PINS-1:0] pull_up_sel;
    output reg             strap_low;
    output reg             core_reset;
    output reg             fetch_start;

    wire            int_rst;
    reg  [PINS-1:0] in_meta_reg;
    reg  [PINS-1:0] in_sync_reg;
    reg             strap_meta_reg;
    reg             strap_sync_reg;
    reg  [7:0]      rel_cnt_reg;
    reg             strap_done_reg;
    reg  [PINS-1:0] en_next;
    reg  [PINS-1:0] dir_next;
    reg  [PINS-1:0] pu_next;
    reg  [7:0]      rel_cnt_next;
    reg             strap_done_next;
    reg             strap_low_next;
    reg             fetch_next;
    reg  [PINS-1:0] out_next;
    reg  [PINS-1:0] oe_n_next;
    reg  [PINS-1:0] pull_up_next;
    reg  [PINS-1:0] pull_dn_next;
    reg  [PINS-1:0] nin_next;
    reg  [PINS-1:0] gin_next;

    // RULE10
    reset_sync u_reset_sync (
        .clk     (clk),
        .rst     (rst),
        .init_n  (chip_init_pin_n),
        .rst_out (int_rst)
    );

    // the fixed-function pins never drive as general pins
    function [PINS-1:0] legal_dir;
        input [PINS-1:0] d;
        begin
            legal_dir = d & ~(`PULLUP_ONLY_MASK | `PULLDN_ONLY_MASK);
        end
    endfunction

    function [PINS-1:0] legal_pull;
        input [PINS-1:0] p;
        begin
            legal_pull = (p | `PULLUP_ONLY_MASK) & ~`PULLDN_ONLY_MASK;
        end
    endfunction

    // pin inputs cross from outside, two flops before use
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            in_meta_reg    <= {PINS{1'b0}};
            in_sync_reg    <= {PINS{1'b0}};
            strap_meta_reg <= 1'b1;
            strap_sync_reg <= 1'b1;
        end else begin
            in_meta_reg    <= pin_in;
            in_sync_reg    <= in_meta_reg;
            strap_meta_reg <= address_drive_strap;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    always @* begin
        en_next  = func_en;
        dir_next = dir_out;
        pu_next  = pull_up_sel;
        if (cfg_write) begin
            en_next  = cfg_func_en;                  // RULE1
            dir_next = legal_dir(cfg_dir_out);       // RULE5 RULE6
            pu_next  = legal_pull(cfg_pull_up);      // RULE5 RULE6
        end
        if (!strap_done_reg && rel_cnt_reg == `STRAP_SAMPLE_CYC
                && !strap_sync_reg)
            en_next = en_next & ~`STRAP_REVERT_MASK; // RULE7 RULE14
    end

    // release sequencing: counter saturates so fetch fires only once
    always @* begin
        rel_cnt_next    = rel_cnt_reg;
        strap_done_next = strap_done_reg;
        strap_low_next  = strap_low;
        if (rel_cnt_reg != 8'hff)
            rel_cnt_next = rel_cnt_reg + 8'h01;
        if (!strap_done_reg && rel_cnt_reg == `STRAP_SAMPLE_CYC) begin
            strap_done_next = 1'b1;                  // RULE14
            strap_low_next  = ~strap_sync_reg;
        end
        // a whole cycle count rounds 6.5 periods up to 7
        fetch_next = (rel_cnt_reg == `FETCH_DELAY_CYC - 8'h02); // RULE13
    end

    // configuration and release sequencing; reset loads the power-on defaults
    always @(posedge clk or posedge int_rst) begin
        if (int_rst) begin
            func_en        <= `RST_FUNC_EN;          // RULE2 RULE3 RULE4
            dir_out        <= `RST_DIR_OUT;          // RULE2
            pull_up_sel    <= `RST_PULL_UP;          // RULE2
            rel_cnt_reg    <= 8'h00;                 // RULE9
            strap_done_reg <= 1'b0;
            strap_low      <= 1'b0;
            fetch_start    <= 1'b0;
            core_reset     <= 1'b1;
        end else begin
            func_en     <= en_next;
            dir_out     <= dir_next;
            pull_up_sel <= pu_next;
            core_reset     <= 1'b0;
            rel_cnt_reg    <= rel_cnt_next;
            strap_done_reg <= strap_done_next;
            strap_low      <= strap_low_next;
            fetch_start    <= fetch_next;
        end
    end

    // pin steering terms, registered below so every pin comes from a flop
    always @* begin
        out_next     = (func_en & cfg_data_out)
                     | (~func_en & normal_out);      // RULE15 RULE8
        oe_n_next    = (func_en & ~dir_out)
                     | (~func_en & normal_oe_n);     // RULE15
        pull_up_next = func_en & ~dir_out & pull_up_sel;
        pull_dn_next = func_en & ~dir_out & ~pull_up_sel;
        nin_next     = ~func_en & in_sync_reg;       // RULE15
        gin_next     = func_en & in_sync_reg;
    end

    // pin steering: normal function when disabled, general otherwise
    always @(posedge clk or posedge int_rst) begin
        if (int_rst) begin
            pin_out     <= {PINS{1'b0}};
            pin_oe_n    <= {PINS{1'b1}};
            pin_pull_up <= `RST_FUNC_EN & `RST_PULL_UP;
            pin_pull_dn <= `RST_FUNC_EN & ~`RST_PULL_UP;
            normal_in   <= {PINS{1'b0}};
            general_in  <= {PINS{1'b0}};
        end else begin
            pin_out     <= out_next;
            pin_oe_n    <= oe_n_next;
            pin_pull_up <= pull_up_next;
            pin_pull_dn <= pull_dn_next;
            normal_in   <= nin_next;
            general_in  <= gin_next;
        end
    end
endmodule // multiplexed_io_pin_control

// ==== src/pin_mux_consts.vh ====
// constants for the multiplexed general pin control block
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH
`define PIN_COUNT           32
`define PIN_IDX_W           5
// power-on function enable: 1 = general pin, 0 = normal function
`define RST_FUNC_EN         32'hffff_fc0f
// power-on direction: 1 = output
`define RST_DIR_OUT         32'h0000_0000
// power-on pull select: 1 = pull-up, 0 = pull-down
`define RST_PULL_UP         32'hffff_fbfd
// pins offering only pull-up (4,5,7,8,9) and only pull-down (6)
`define PULLUP_ONLY_MASK    32'h0000_03b0
`define PULLDN_ONLY_MASK    32'h0000_0040
// pins that return to normal function on a low strap (26, 29)
`define STRAP_REVERT_MASK   32'h2400_0000
// reset release to first fetch, in half periods (6.5 periods)
`define FETCH_DELAY_HALF    8'h0d
`define FETCH_DELAY_CYC     8'h07
// strap sampled this many cycles after reset release
`define STRAP_SAMPLE_CYC    8'h01
`endif

// ==== src/reset_sync.v ====
// three-stage reset synchroniser: asynchronous assert, clocked release
`timescale 1ns/1ps
module reset_sync (
    clk,
    rst,
    init_n,
    rst_out
);
    input  wire clk;
    input  wire rst;
    input  wire init_n;
    output reg  rst_out;

    reg  stage1_reg;
    reg  stage2_reg;
    wire arst;

    // any low on the pin resets at once; release waits for clock edges
    assign arst = rst | ~init_n;

    always @(posedge clk or posedge arst) begin
        if (arst) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            rst_out    <= 1'b1;
        end else begin
            stage1_reg <= 1'b1;
            stage2_reg <= stage1_reg;
            rst_out    <= ~stage2_reg;
        end
    end
endmodule // reset_sync

// ==== test/pin_world.sv ====
// board model: resolves each pin from device drive and weak pulls
`timescale 1ns/1ps
module pin_world (
    input  wire [31:0] pin_out,
    input  wire [31:0] pin_oe_n,
    input  wire [31:0] pin_pull_up,
    input  wire [31:0] pin_pull_dn,
    output wire [31:0] pin_in
);
    // a pin nobody drives or pulls shows the inverse of its current pin_out value,
    // so a design that forgets its pull cannot pass by luck
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & (pin_pull_up
        | (~pin_pull_dn & ~pin_out)));
endmodule // pin_world

// ==== test/pin_mux_sva.sv ====
// assertions on the multiplexed general pin control ports
`timescale 1ns/1ps
module pin_mux_sva #(
    parameter PINS = 32
) (
    input wire            clk,
    input wire            rst,
    input wire            cfg_write,
    input wire [PINS-1:0] cfg_func_en,
    input wire [PINS-1:0] func_en,
    input wire [PINS-1:0] dir_out,
    input wire [PINS-1:0] pin_pull_up,
    input wire [PINS-1:0] pin_pull_dn,
    input wire            strap_low,
    input wire            core_reset,
    input wire            fetch_start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_dir_forced:
        assert property (dir_out[9:4] == 6'h00) else $error("output on 4-9");
    a_pull_down6:
        assert property (!pin_pull_up[6]) else $error("pin 6 pulled up");
    a_pullup_only:
        assert property ((pin_pull_dn & 32'h0000_03b0) == 32'h0)
        else $error("pull-up-only pin pulled down");
    a_fetch_pulse:
        assert property (fetch_start |=> !fetch_start) else $error("long");
    a_fetch_delay:
        assert property ($fell(core_reset) ##1 !core_reset [*5]
            |-> ##[0:2] fetch_start) else $error("fetch not started");
    a_strap_revert:
        assert property ($rose(strap_low) |-> !func_en[26] && !func_en[29])
        else $error("strap pins not reverted");
    a_cfg_func:
        assert property (cfg_write && !core_reset |=> (func_en | 32'h2400_0000)
            == ($past(cfg_func_en) | 32'h2400_0000)) else $error("no load");
    a_reset_dflt:
        assert property ($rose(core_reset) |=> func_en == 32'hffff_fc0f
            && dir_out == 32'h0) else $error("defaults not restored");
endmodule // pin_mux_sva
bind multiplexed_io_pin_control pin_mux_sva #(.PINS(PINS)) i_pin_mux_sva (.*);

// ==== test/multiplexed_io_pin_control_bench.sv ====
// bench for the multiplexed general pin control block
`timescale 1ns/1ps
module multiplexed_io_pin_control_bench;
    reg         clk, rst, chip_init_pin_n, address_drive_strap, cfg_write;
    reg  [31:0] cfg_func_en, cfg_dir_out, cfg_pull_up, cfg_data_out;
    reg  [31:0] normal_out, normal_oe_n;
    wire [31:0] pin_in, pin_out, pin_oe_n, pin_pull_up, pin_pull_dn;
    wire [31:0] normal_in, general_in, func_en, dir_out, pull_up_sel;
    wire        strap_low, core_reset, fetch_start;
    integer     error_cnt, num_checks, n;
    multiplexed_io_pin_control i_multiplexed_io_pin_control (.*);
    pin_world i_pin_world (.*);
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task tick(input integer k);
        begin
            repeat (k) @(posedge clk);
            #2;
        end
    endtask
    task cfg(input [31:0] e, input [31:0] d, input [31:0] p, input [31:0] o);
        begin
            {cfg_func_en, cfg_dir_out, cfg_pull_up, cfg_data_out} = {e, d, p, o};
            cfg_write = 1;
            tick(1);
            cfg_write = 0;
            tick(6);
        end
    endtask
    // the reset pin is held the full 1 ms each time, so boots dominate runtime
    task boot(input s);
        begin
            chip_init_pin_n = 0;
            address_drive_strap = s;
            tick(40000);
            chk({31'h0, core_reset}, 32'h1);
            chip_init_pin_n = 1;
            n = 0;
            while (fetch_start !== 1'b1 && n < 20) begin
                tick(1);
                n = n + 1;
            end
            chk({31'h0, n >= 8 && n <= 12}, 32'h1);
            if (n == 20)
                stop_test;
            tick(2);
            $display("boot done");
        end
    endtask
    task t_defaults;
        begin
            chk(func_en, 32'hffff_fc0f);
            chk(pull_up_sel, 32'hffff_fbfd);
            chk(pin_pull_up, 32'hffff_f80d);
            chk(pin_pull_dn, 32'h0000_0402);
            chk(pin_oe_n, 32'hffff_fd5f);
            chk(pin_out & 32'h3f0, normal_out & 32'h3f0);
            chk({31'h0, strap_low}, 32'h0);
            chk({31'h0, core_reset}, 32'h0);
            $display("defaults done");
        end
    endtask
    task t_drive;
        begin
            cfg(32'hffff_ffff, 32'hffff_ffff, 32'h0, 32'ha5a5_5a5a);
            chk(dir_out, 32'hffff_fc0f);
            chk(pin_oe_n, 32'h0000_03f0);
            chk(pin_out & 32'hffff_fc0f, 32'ha5a5_580a);
            chk(pin_pull_up, 32'h0000_03b0);
            chk(pin_pull_dn, 32'h0000_0040);
            chk(general_in, 32'ha5a5_5bba);
            $display("drive done");
        end
    endtask
    task t_pulls;
        begin
            cfg(32'hffff_ffff, 32'h0, 32'h5555_aaaa, 32'h0);
            chk(pull_up_sel, 32'h5555_abba);
            chk(pin_pull_up, 32'h5555_abba);
            chk(pin_pull_dn, 32'haaaa_5445);
            chk(pin_oe_n, 32'hffff_ffff);
            chk(general_in, 32'h5555_abba);
            $display("pulls done");
        end
    endtask
    task t_disabled;
        begin
            cfg(32'h0, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff);
            chk(pin_oe_n, normal_oe_n);
            chk(pin_out, normal_out);
            chk(pin_pull_up | pin_pull_dn, 32'h0);
            chk(normal_in, 32'h0000_03f0);
            $display("disabled done");
        end
    endtask
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {rst, chip_init_pin_n, address_drive_strap, cfg_write} = 4'h8;
        {cfg_func_en, cfg_dir_out, cfg_pull_up, cfg_data_out} = 128'h0;
        normal_out = 32'h0000_02a0;
        normal_oe_n = 32'h0000_0150;
        error_cnt = 0;
        num_checks = 0;
        tick(20);
        rst = 0;
        boot(1'b1);
        t_defaults;
        t_drive;
        t_pulls;
        t_disabled;
        boot(1'b0);
        chk(func_en, 32'hdbff_fc0f);
        chk({31'h0, strap_low}, 32'h1);
        chk(dir_out, 32'h0);
        stop_test;
    end
endmodule // multiplexed_io_pin_control_bench
